// [hdl/proximity_sensor_i2c_interface.sv]
// serial target, register file and proximity interrupt logic
`timescale 1ns/10ps
module proximity_sensor_i2c_interface #(
	parameter int         MEAS_BASE = 5000,
	parameter logic [7:0] ID_LOW    = 8'h5A  // arbitrary identity value
) (
	input  wire logic                       clk,
	input  wire logic                       rstn,
	input  wire logic                       scl_i,
	input  wire logic                       sda_i,
	output logic                            sda_o,
	output logic                            sda_oe,
	input  wire logic [15:0]                prox_raw,
	input  wire logic                       prox_valid,
	output logic                            meas_req,
	output logic                            meas_on,
	output logic [prox_pkg::IT_W-1:0]       integ_time,
	output logic                            int_n
);
	import prox_pkg::*;

	// ==========================================================
	// pin synchronisers
	logic scl_s1_q, scl_s2_q, scl_s3_q, sda_s1_q, sda_s2_q, sda_s3_q;
	logic scl_rise, scl_fall, start_c, stop_c;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			{scl_s1_q, scl_s2_q, scl_s3_q} <= 3'h7;
			{sda_s1_q, sda_s2_q, sda_s3_q} <= 3'h7;
		end else begin
			{scl_s1_q, scl_s2_q, scl_s3_q} <= {scl_i, scl_s1_q, scl_s2_q};
			{sda_s1_q, sda_s2_q, sda_s3_q} <= {sda_i, sda_s1_q, sda_s2_q};
		end
	end

	assign scl_rise = scl_s2_q & ~scl_s3_q;
	assign scl_fall = ~scl_s2_q & scl_s3_q;
	assign start_c  = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
	assign stop_c   = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;

	// ==========================================================
	// serial target state machine
	i2c_state_t  state_q, state_d;
	logic [3:0]  bit_q, bit_d;
	logic [7:0]  shift_q, shift_d, cmd_q, cmd_d, wlo_q, wlo_d, nb;
	logic        rw_q, rw_d, hi_q, hi_d, ack_q, ack_d, oe_q, oe_d;
	logic        wr_en, rd_clr;
	logic [15:0] tx_word;

	always_comb begin
		state_d = state_q;
		bit_d   = bit_q;
		shift_d = shift_q;
		cmd_d   = cmd_q;
		wlo_d   = wlo_q;
		rw_d    = rw_q;
		hi_d    = hi_q;
		ack_d   = ack_q;
		oe_d    = oe_q;
		wr_en   = 1'b0;
		rd_clr  = 1'b0;
		nb      = tx_word[7:0];
		if (start_c) begin
			state_d = ST_ADDR;
			bit_d   = 4'h0;
			hi_d    = 1'b0;
			oe_d    = 1'b0;
		end else if (stop_c) begin
			state_d = ST_IDLE;
			oe_d    = 1'b0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
				end
				ST_ADDR, ST_CMD, ST_WR: begin
					if (scl_rise) begin
						shift_d = {shift_q[6:0], sda_s2_q};
						bit_d   = bit_q + 4'h1;
					end
					if (scl_fall && bit_q == BITS_BYTE) begin
						bit_d = 4'h0;
						if (state_q == ST_ADDR) begin
							if (shift_q[7:1] == DEV_ADDR) begin
								state_d = ST_ADDR_ACK;
								rw_d    = shift_q[0];
								oe_d    = 1'b1;
							end else begin
								state_d = ST_IDLE;
							end
						end else if (state_q == ST_CMD) begin
							cmd_d   = shift_q;
							state_d = ST_CMD_ACK;
							oe_d    = 1'b1;
						end else begin
							// low byte parks, high byte commits the pair
							state_d = ST_WR_ACK;
							oe_d    = 1'b1;
							wlo_d   = shift_q;
							wr_en   = hi_q;
							hi_d    = ~hi_q;
						end
					end
				end
				ST_ADDR_ACK: begin
					if (scl_fall) begin
						if (rw_q) begin
							state_d = ST_RD;
							shift_d = nb;
							oe_d    = ~nb[7];
						end else begin
							state_d = ST_CMD;
							oe_d    = 1'b0;
						end
					end
				end
				ST_CMD_ACK, ST_WR_ACK: begin
					if (scl_fall) begin
						state_d = ST_WR;
						oe_d    = 1'b0;
						if (state_q == ST_CMD_ACK) begin
							hi_d = 1'b0;
						end
					end
				end
				ST_RD: begin
					if (scl_rise) begin
						bit_d = bit_q + 4'h1;
					end
					if (scl_fall && bit_q == BITS_BYTE) begin
						state_d = ST_RD_ACK;
						bit_d   = 4'h0;
						oe_d    = 1'b0;
					end else if (scl_fall && bit_q != 4'h0) begin
						shift_d = {shift_q[6:0], 1'b0};
						oe_d    = ~shift_q[6];
					end
				end
				ST_RD_ACK: begin
					if (scl_rise) begin
						ack_d = ~sda_s2_q;
					end
					if (scl_fall) begin
						if (ack_q) begin
							nb      = tx_word[15:8];
							state_d = ST_RD;
							hi_d    = 1'b1;
							shift_d = nb;
							oe_d    = ~nb[7];
							rd_clr  = (cmd_q == CMD_FLAG);
						end else begin
							state_d = ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_q <= ST_IDLE;
			bit_q   <= 4'h0;
			shift_q <= 8'h00;
			cmd_q   <= 8'h00;
			wlo_q   <= 8'h00;
			rw_q    <= 1'b0;
			hi_q    <= 1'b0;
			ack_q   <= 1'b0;
			oe_q    <= 1'b0;
		end else begin
			state_q <= state_d;
			bit_q   <= bit_d;
			shift_q <= shift_d;
			cmd_q   <= cmd_d;
			wlo_q   <= wlo_d;
			rw_q    <= rw_d;
			hi_q    <= hi_d;
			ack_q   <= ack_d;
			oe_q    <= oe_d;
		end
	end

	assign sda_oe = oe_q;

	// ==========================================================
	// registers, measurement pacing and interrupt
	logic [15:0]      conf12_q, conf12_d, conf3_q, conf3_d, canc_q, canc_d;
	logic [15:0]      lower_q, lower_d, upper_q, upper_d, result_q, result_d, res_c;
	logic [1:0]       flag_q, flag_d;
	logic [2:0]       cnt_up_q, cnt_up_d, cnt_lo_q, cnt_lo_d, tgt;
	logic [TMR_W-1:0] tmr_q, tmr_d, period;
	logic             near_q, near_d, int_n_q, int_n_d, req_q, req_d, on_q, on_d;
	logic             hit_up, hit_lo, fire_up, fire_lo, logic_mode, low_q;

	// saturating run length of consecutive out-of-range results
	function automatic logic [2:0] pers_next(input logic hit, input logic [2:0] cnt,
		input logic [2:0] lim);
		return !hit ? 3'h0 : (cnt == lim) ? cnt : cnt + 3'h1;
	endfunction

	always_comb begin
		case (cmd_q)
			CMD_RSV0:    tx_word = RST_RSV0;
			CMD_CONF12:  tx_word = conf12_q;
			CMD_CONF3MS: tx_word = conf3_q;
			CMD_CANC:    tx_word = canc_q;
			CMD_LOWER:   tx_word = lower_q;
			CMD_UPPER:   tx_word = upper_q;
			CMD_DATA1:   tx_word = result_q;
			CMD_FLAG:    tx_word = {6'h00, flag_q, 8'h00};
			CMD_ID:      tx_word = {1'b0, DEV_ADDR, ID_LOW};
			default:     tx_word = RST_ZERO;
		endcase
	end

	assign logic_mode = conf3_q[LOGIC_BIT];
	assign tgt        = {1'b0, conf12_q[PERS_LSB +: 2]} + 3'h1;
	assign period     = TMR_W'(MEAS_BASE << conf12_q[DUTY_LSB +: 2]);
	assign res_c      = (prox_raw > canc_q) ? prox_raw - canc_q : 16'h0000;
	assign hit_up     = res_c > upper_q;
	assign hit_lo     = res_c < lower_q;
	assign fire_up    = prox_valid && hit_up && cnt_up_q == tgt - 3'h1;
	assign fire_lo    = prox_valid && hit_lo && cnt_lo_q == tgt - 3'h1;

	always_comb begin
		conf12_d = conf12_q;
		conf3_d  = conf3_q;
		canc_d   = canc_q;
		lower_d  = lower_q;
		upper_d  = upper_q;
		result_d = result_q;
		cnt_up_d = cnt_up_q;
		cnt_lo_d = cnt_lo_q;
		flag_d   = flag_q;
		near_d   = near_q;
		req_d    = 1'b0;
		tmr_d    = tmr_q;
		if (wr_en) begin
			// read-only and reserved codes swallow the data
			unique case (cmd_q)
				CMD_CONF12:  conf12_d = {shift_q, wlo_q};
				CMD_CONF3MS: conf3_d  = {shift_q, wlo_q};
				CMD_CANC:    canc_d   = {shift_q, wlo_q};
				CMD_LOWER:   lower_d  = {shift_q, wlo_q};
				CMD_UPPER:   upper_d  = {shift_q, wlo_q};
				default: begin
				end
			endcase
		end
		if (prox_valid) begin
			result_d = res_c;
			cnt_up_d = pers_next(hit_up, cnt_up_q, tgt);
			cnt_lo_d = pers_next(hit_lo, cnt_lo_q, tgt);
		end
		if (rd_clr) begin
			flag_d = 2'h0;
		end
		// set after clear so an event in the read cycle survives
		if (!logic_mode) begin
			if (fire_up && conf12_q[INT_EN_LSB]) begin
				flag_d[FLAG_UP] = 1'b1;
			end
			if (fire_lo && conf12_q[INT_EN_LSB + 1]) begin
				flag_d[FLAG_LOW] = 1'b1;
			end
		end
		if (fire_up) begin
			near_d = 1'b1;
		end else if (fire_lo) begin
			near_d = 1'b0;
		end
		int_n_d = logic_mode ? ~near_d : ~(|flag_d);
		on_d    = ~conf12_d[SD_BIT];
		if (!on_q) begin
			tmr_d = '0;
		end else if (tmr_q == '0) begin
			req_d = 1'b1;
			tmr_d = period - TMR_W'(1);
		end else begin
			tmr_d = tmr_q - TMR_W'(1);
		end
		// a partial run re-measures at once instead of waiting a duty period
		if (conf3_q[SMART_BIT] && prox_valid &&
			((cnt_up_d != 3'h0 && cnt_up_d != tgt) ||
			 (cnt_lo_d != 3'h0 && cnt_lo_d != tgt))) begin
			tmr_d = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			conf12_q <= RST_CONF12;
			conf3_q  <= RST_ZERO;
			canc_q   <= RST_ZERO;
			lower_q  <= RST_ZERO;
			upper_q  <= RST_ZERO;
			result_q <= RST_ZERO;
			cnt_up_q <= 3'h0;
			cnt_lo_q <= 3'h0;
			flag_q   <= 2'h0;
			near_q   <= 1'b0;
			int_n_q  <= 1'b1;
			req_q    <= 1'b0;
			on_q     <= 1'b0;
			tmr_q    <= '0;
			low_q    <= 1'b0;
		end else begin
			conf12_q <= conf12_d;
			conf3_q  <= conf3_d;
			canc_q   <= canc_d;
			lower_q  <= lower_d;
			upper_q  <= upper_d;
			result_q <= result_d;
			cnt_up_q <= cnt_up_d;
			cnt_lo_q <= cnt_lo_d;
			flag_q   <= flag_d;
			near_q   <= near_d;
			int_n_q  <= int_n_d;
			req_q    <= req_d;
			on_q     <= on_d;
			tmr_q    <= tmr_d;
			low_q    <= 1'b0;
		end
	end

	assign sda_o      = low_q;
	assign int_n      = int_n_q;
	assign meas_req   = req_q;
	assign meas_on    = on_q;
	assign integ_time = conf12_q[IT_LSB +: IT_W];

	// ==========================================================
	// assertions
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	a_addr_match_ack: assert property (state_q == ST_ADDR && !start_c && !stop_c && scl_fall
		&& bit_q == BITS_BYTE && shift_q[7:1] == DEV_ADDR |=> oe_q && state_q == ST_ADDR_ACK)
		else $error("own address not acknowledged");
	a_addr_foreign: assert property (state_q == ST_ADDR && !start_c && !stop_c && scl_fall
		&& bit_q == BITS_BYTE && shift_q[7:1] != DEV_ADDR |=> !oe_q [*2])
		else $error("foreign address acknowledged");
	a_cmd_ack_held: assert property (state_q == ST_CMD_ACK && !scl_fall && !start_c
		&& !stop_c |-> oe_q)
		else $error("command acknowledge dropped early");
	a_upper_write: assert property (wr_en && cmd_q == CMD_UPPER
		|=> upper_q == {$past(shift_q), $past(wlo_q)})
		else $error("upper threshold not written low byte first");
	a_read_low_first: assert property (state_q == ST_ADDR_ACK && scl_fall && rw_q
		&& !start_c && !stop_c |=> shift_q == $past(tx_word[7:0]) && oe_q == !shift_q[7])
		else $error("read did not start with low byte");
	a_flag_clear: assert property (rd_clr && !fire_up && !fire_lo |=> flag_q == 2'h0)
		else $error("flag read did not clear");
	a_int_hold: assert property (!logic_mode && $past(!logic_mode) && flag_q != 2'h0
		|-> !int_n_q)
		else $error("interrupt released while flag pending");
	a_persist_gate: assert property ($rose(flag_q[FLAG_UP])
		|-> $past(cnt_up_q) == $past(tgt) - 3'h1 && $past(prox_valid))
		else $error("interrupt before persistence count");
	// a flag read may still clear old flags here, but nothing new may latch
	a_logic_level: assert property (logic_mode && $past(logic_mode) |-> int_n_q == !near_q
		&& (flag_q & ~$past(flag_q)) == 2'h0)
		else $error("logic mode level wrong");
	a_cancel_sub: assert property (prox_valid && prox_raw > canc_q
		|=> result_q == $past(prox_raw) - $past(canc_q))
		else $error("cancellation not applied");
	a_smart_rush: assert property (conf3_q[SMART_BIT] && on_q && $past(on_q) && prox_valid
		&& cnt_up_d == 3'h1 && tgt > 3'h1 |-> ##2 req_q)
		else $error("smart persistence did not re-measure");
	c_word_write: cover property (wr_en ##1 state_q == ST_WR_ACK);
	c_word_read: cover property (state_q == ST_RD_ACK && scl_fall && !ack_q);
	c_flag_event: cover property ($rose(flag_q[FLAG_LOW]));
	c_logic_near: cover property (logic_mode && $fell(int_n_q));
	c_smart_rush: cover property (conf3_q[SMART_BIT] && prox_valid && cnt_up_d == 3'h1 ##2 req_q);
endmodule

// [hdl/prox_pkg.sv]
// constants, field layout and state type for the proximity sensor serial interface
package prox_pkg;
	localparam logic [6:0]  DEV_ADDR     = 7'h41;
	localparam logic [7:0]  CMD_RSV0     = 8'h00;
	localparam logic [7:0]  CMD_CONF12   = 8'h03;
	localparam logic [7:0]  CMD_CONF3MS  = 8'h04;
	localparam logic [7:0]  CMD_CANC     = 8'h05;
	localparam logic [7:0]  CMD_LOWER    = 8'h06;
	localparam logic [7:0]  CMD_UPPER    = 8'h07;
	localparam logic [7:0]  CMD_DATA1    = 8'h08;
	localparam logic [7:0]  CMD_FLAG     = 8'h0D;
	localparam logic [7:0]  CMD_ID       = 8'h0E;
	localparam logic [15:0] RST_RSV0     = 16'h0101;
	localparam logic [15:0] RST_CONF12   = 16'h0001;
	localparam logic [15:0] RST_ZERO     = 16'h0000;
	// field positions inside the 16-bit words
	localparam int          SD_BIT       = 0;
	localparam int          IT_LSB       = 1;
	localparam int          IT_W         = 3;
	localparam int          PERS_LSB     = 4;
	localparam int          DUTY_LSB     = 6;
	localparam int          INT_EN_LSB   = 8;
	localparam int          SMART_BIT    = 4;
	localparam int          LOGIC_BIT    = 14;
	localparam int          FLAG_UP      = 1;
	localparam int          FLAG_LOW     = 0;
	localparam int          TMR_W        = 16;
	localparam logic [3:0]  BITS_BYTE    = 4'h8;

	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
		ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
	} i2c_state_t;
endpackage

// [bench/i2c_host_model.sv]
// bus controller model that issues word writes and word reads
`timescale 1ns/10ps
module i2c_host_model (
	output logic      scl_line,
	output logic      sda_low,
	input  wire logic sda_line
);
	import prox_pkg::*;
	// quarter bus period; raised for a slow host
	int q = 40;

	initial begin
		scl_line = 1'b1;
		sda_low  = 1'b0;
	end

	// ==========================================
	// bit level
	// clock only moves inside frames, idles high
	task automatic bit_io(input logic b, output logic r);
		sda_low = ~b;
		#(q) scl_line = 1'b1;
		#(q) r = sda_line;
		#(q) scl_line = 1'b0;
		#(q);
	endtask

	// also serves as repeated start from a low clock
	task automatic start_cond();
		sda_low = 1'b0;
		#(q) scl_line = 1'b1;
		#(q) sda_low = 1'b1;
		#(q) scl_line = 1'b0;
		#(q);
	endtask

	task automatic stop_cond();
		sda_low = 1'b1;
		#(q) scl_line = 1'b1;
		#(q) sda_low = 1'b0;
		#(2*q);
	endtask

	// ==========================================
	// byte level
	task automatic put_byte(input logic [7:0] d, output logic nack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, nack);
	endtask

	task automatic get_byte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(last, r);
	endtask

	// ==========================================
	// word transfers, the only kind offered
	task automatic write_word(input logic [6:0] a, input logic [7:0] cmd,
		input logic [15:0] d, output logic [3:0] nk);
		nk = 4'hF;
		start_cond();
		put_byte({a, 1'b0}, nk[3]);
		// a foreign address gets no ack, so give up at once
		if (!nk[3]) begin
			put_byte(cmd, nk[2]);
			put_byte(d[7:0], nk[1]);
			put_byte(d[15:8], nk[0]);
		end
		stop_cond();
	endtask

	task automatic read_word(input logic [7:0] cmd, output logic [15:0] d,
		output logic [2:0] nk);
		start_cond();
		put_byte({DEV_ADDR, 1'b0}, nk[2]);
		put_byte(cmd, nk[1]);
		start_cond();
		put_byte({DEV_ADDR, 1'b1}, nk[0]);
		get_byte(1'b0, d[7:0]);
		get_byte(1'b1, d[15:8]);
		stop_cond();
	endtask
endmodule

// [bench/testbench.sv]
// self-checking bench for the proximity sensor serial interface
`timescale 1ns/10ps
module testbench;
	import prox_pkg::*;
	localparam logic [7:0] ID_VAL = 8'h3C; // arbitrary identity value
	logic            clk;
	logic            rstn;
	logic            scl;
	logic            host_low;
	logic            sda;
	logic            sda_o;
	logic            sda_oe;
	logic [15:0]     front_val;
	logic            prox_valid;
	logic            meas_req;
	logic            meas_on;
	logic [IT_W-1:0] integ_time;
	logic            int_n;
	int              n_fail = 0;
	int              n_compared = 0;

	// pull-up on the data wire, any party pulling low wins
	assign sda = (host_low || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;

	proximity_sensor_i2c_interface #(.MEAS_BASE(20), .ID_LOW(ID_VAL))
		proximity_sensor_i2c_interface_i (
		.clk        (clk),
		.rstn       (rstn),
		.scl_i      (scl),
		.sda_i      (sda),
		.sda_o      (sda_o),
		.sda_oe     (sda_oe),
		.prox_raw   (front_val),
		.prox_valid (prox_valid),
		.meas_req   (meas_req),
		.meas_on    (meas_on),
		.integ_time (integ_time),
		.int_n      (int_n)
	);

	i2c_host_model i2c_host_model_i (
		.scl_line (scl),
		.sda_low  (host_low),
		.sda_line (sda)
	);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// front end answers each request one cycle later
	always @(negedge clk) begin
		prox_valid <= meas_req;
	end

	// ==========================================
	// compare and access tasks
	task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk1(input string what, input logic exp, input logic got);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic give_verdict();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
		logic [3:0] nk;
		i2c_host_model_i.write_word(DEV_ADDR, cmd, d, nk);
		chk1("write ack", 1'b0, |nk);
	endtask

	task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
		logic [15:0] d;
		logic [2:0]  nk;
		i2c_host_model_i.read_word(cmd, d, nk);
		chk1("read ack", 1'b0, |nk);
		chk16("read word", exp, d);
	endtask

	// waits for n results, bounded; settles before returning
	task automatic meas(input int n);
		int k;
		for (int m = 0; m < n; m++) begin
			k = 0;
			@(posedge clk);
			while (prox_valid !== 1'b1 && k < 500) begin
				@(posedge clk);
				k++;
			end
			if (k >= 500) begin
				n_fail++;
				$display("FAIL prox_valid expected 1 seen 0");
				give_verdict();
			end
		end
		repeat (3) @(negedge clk);
	endtask

	// cycles from one result to the next, both found through the bounded wait
	task automatic gap(input logic [15:0] exp);
		longint t0;
		meas(1);
		t0 = $time;
		meas(1);
		chk16("meas period", exp, 16'(($time - t0) / 20));
	endtask

	task automatic level(input logic [15:0] v);
		@(negedge clk);
		front_val = v;
	endtask

	// ==========================================
	// main sequence
	initial begin
		logic [3:0] nk4;
		rstn = 1'b0;
		front_val = 16'h0800;
		repeat (16) @(negedge clk);
		rstn = 1'b1;
		repeat (4) @(negedge clk);
		chk1("int_n", 1'b1, int_n);
		chk1("meas_on", 1'b0, meas_on);
		rd(CMD_RSV0, RST_RSV0);
		rd(CMD_ID, {1'b0, DEV_ADDR, ID_VAL});
		rd(CMD_CONF12, RST_CONF12);
		wr(CMD_UPPER, 16'h1234);
		rd(CMD_UPPER, 16'h1234);
		i2c_host_model_i.write_word(7'h42, CMD_UPPER, 16'hFFFF, nk4);
		chk1("foreign ack", 1'b1, nk4[3]);
		rd(CMD_UPPER, 16'h1234);
		i2c_host_model_i.q = 60;
		wr(CMD_LOWER, 16'h0100);
		i2c_host_model_i.q = 40;
		wr(CMD_CANC, 16'h0010);
		rd(CMD_LOWER, 16'h0100);
		// enabled, integration 5, two in a row, both thresholds armed
		wr(CMD_CONF12, 16'h031A);
		chk1("meas_on", 1'b1, meas_on);
		chk16("integ_time", 16'h0005, {13'h0000, integ_time});
		gap(16'h0014);
		level(16'h2000);
		meas(1);
		chk1("int_n", 1'b1, int_n);
		meas(1);
		chk1("int_n", 1'b0, int_n);
		level(16'h0800);
		rd(CMD_DATA1, 16'h07F0);
		chk1("int_n", 1'b0, int_n);
		rd(CMD_FLAG, 16'h0200);
		chk1("int_n", 1'b1, int_n);
		level(16'h0005);
		meas(2);
		chk1("int_n", 1'b0, int_n);
		rd(CMD_DATA1, 16'h0000);
		level(16'h0800);
		rd(CMD_FLAG, 16'h0100);
		chk1("int_n", 1'b1, int_n);
		wr(CMD_CONF3MS, 16'h4000);
		level(16'h2000);
		meas(2);
		chk1("int_n", 1'b0, int_n);
		rd(CMD_FLAG, 16'h0000);
		chk1("int_n", 1'b0, int_n);
		level(16'h0005);
		meas(2);
		chk1("int_n", 1'b1, int_n);
		// smart mode: half a run re-measures at once, a full period would leave int_n high
		wr(CMD_CONF3MS, 16'h0010);
		level(16'h2000);
		meas(1);
		chk1("int_n", 1'b0, int_n);
		rd(CMD_FLAG, 16'h0200);
		chk1("int_n", 1'b1, int_n);
		// duty step one doubles the period
		wr(CMD_CONF12, 16'h035A);
		gap(16'h0028);
		rd(CMD_RSV0, RST_RSV0);
		give_verdict();
	end
endmodule
